// >>> hw/sgl_pkg.sv
package sgl_pkg;
  // width of the gain code
  localparam int GAIN_W = 8;
  // latch value before the first load
  localparam logic [7:0] GAIN_RST = 8'h00;
  // bits in a complete word
  localparam int WORD_BITS = 8;
  // sync stages for crossing into clk_i
  localparam int SYNC_STAGES = 2;
  // core clock period in ns
  localparam int CLK_PERIOD_NS = 8;
  // link clock period in the bench, ns
  localparam int LINK_PERIOD_NS = 160;
endpackage

// >>> hw/sgl_link_if.sv
`timescale 1ns/1ps
// link-domain values handed to the core domain
interface sgl_link_if #(parameter int W = 8);
  logic [W-1:0] code; // latched gain code
  logic upd_tgl; // toggles once per applied word
  modport src (output code, output upd_tgl);
  modport dst (input code, input upd_tgl);
endinterface // sgl_link_if

// >>> hw/sgl_sync.sv
`timescale 1ns/1ps
// two-flop level synchroniser
module sgl_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_ff; // first stage, read only by second
  logic [W-1:0] sync_ff; // second stage
  // two stages, constant reset
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end
  assign q_o = sync_ff;
endmodule // sgl_sync

// >>> hw/sgl_loader.sv
`timescale 1ns/1ps
// Contract
// - eight-bit code, most significant bit first
// - rising serial clock captures bit into master
// - falling serial clock moves master to slave
// - eight-bit shifter feeds eight-bit latch
// - enable rising edge copies shifter into latch
// - enable high blocks further shifting
// - enable falling edge freezes the latch
// - enable low lets data shift in
// - sleep low: forward off, reverse on
// - sleep high: forward on, reverse off
// - code is unsigned gain, linear rising
module sgl_loader #(
  parameter int GAIN_W = sgl_pkg::GAIN_W
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic serial_clk_i,
  input wire logic serial_gain_in_i,
  input wire logic load_enable_n_i,
  input wire logic amp_sleep_n_i,
  output logic [GAIN_W-1:0] gain_code_o,
  output logic gain_update_o,
  output logic fwd_amp_en_o,
  output logic rev_amp_en_o
);
  // elaboration check: the shifter slice needs the documented word length
  if (GAIN_W != sgl_pkg::WORD_BITS) begin : g_bad_width
    $error("sgl_loader: GAIN_W must equal word length");
  end

  sgl_link_if #(.W(GAIN_W)) lnk ();

  // ---------------- link domain (serial clock) ----------------
  logic [GAIN_W-1:0] master_ff; // master stage, loaded on rising edge
  logic [GAIN_W-1:0] slave_ff; // slave stage, loaded on falling edge
  logic [GAIN_W-1:0] latch_ff; // parallel latch driving the gain
  logic upd_tgl_ff; // event toggle toward the core
  logic [GAIN_W-1:0] nxt_master;

  // master samples the new bit behind the slave contents
  assign nxt_master = {slave_ff[GAIN_W-2:0], serial_gain_in_i};

  // master capture only while enable is low; high blocks shifting
  always_ff @(posedge serial_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      master_ff <= '0;
    end else if (!load_enable_n_i) begin
      master_ff <= nxt_master;
    end // else hold
  end

  // slave follows master on falling edge, gated like master
  always_ff @(negedge serial_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      slave_ff <= '0;
    end else if (!load_enable_n_i) begin
      slave_ff <= master_ff;
    end
  end

  // latch takes the shifter on enable rising edge, holds otherwise
  always_ff @(posedge load_enable_n_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      latch_ff <= sgl_pkg::GAIN_RST;
      upd_tgl_ff <= 1'b0;
    end else begin
      latch_ff <= slave_ff;
      upd_tgl_ff <= ~upd_tgl_ff;
    end
  end // enable falling edge changes nothing: latch frozen

  assign lnk.code = latch_ff;
  assign lnk.upd_tgl = upd_tgl_ff;

  // ---------------- core domain (clk_i) ----------------
  logic [GAIN_W-1:0] code_sync; // code, changes on the same enable edge as the toggle
  logic tgl_sync; // synchronised update toggle
  logic sleep_n_sync; // synchronised sleep level
  logic tgl_seen_ff; // last toggle value seen
  logic [GAIN_W-1:0] gain_ff;
  logic upd_ff;
  logic fwd_ff;
  logic rev_ff;

  sgl_sync #(.W(GAIN_W)) u_code_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i(lnk.code),
    .q_o(code_sync)
  );
  sgl_sync #(.W(1)) u_tgl_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i(lnk.upd_tgl),
    .q_o(tgl_sync)
  );
  sgl_sync #(.W(1)) u_sleep_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i(amp_sleep_n_i),
    .q_o(sleep_n_sync)
  );

  // toggle edge held one more cycle so every code bit has settled when it is taken
  logic tgl_edge_ff;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tgl_edge_ff <= 1'b0;
    end else begin
      tgl_edge_ff <= tgl_sync ^ tgl_seen_ff;
    end
  end

  // gain output updates once per applied word, unsigned code
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tgl_seen_ff <= 1'b0;
      gain_ff <= sgl_pkg::GAIN_RST;
      upd_ff <= 1'b0;
    end else begin
      tgl_seen_ff <= tgl_sync;
      upd_ff <= tgl_edge_ff;
      if (tgl_edge_ff) begin
        gain_ff <= code_sync;
      end
    end
  end

  // amplifier mode from sleep level
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fwd_ff <= 1'b0;
      rev_ff <= 1'b1;
    end else begin
      fwd_ff <= sleep_n_sync;
      rev_ff <= ~sleep_n_sync;
    end
  end

  assign gain_code_o = gain_ff;
  assign gain_update_o = upd_ff;
  assign fwd_amp_en_o = fwd_ff;
  assign rev_amp_en_o = rev_ff;

  // ---------------- checks ----------------
  chk_mode_exclusive: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    fwd_amp_en_o != rev_amp_en_o) else $error("amp modes not exclusive");
  chk_sleep_follow: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(sleep_n_sync) |=> fwd_amp_en_o) else $error("forward not enabled");
  chk_sleep_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(sleep_n_sync) |=> rev_amp_en_o && !fwd_amp_en_o) else $error("reverse not enabled");
  chk_gain_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !gain_update_o |-> gain_code_o == $past(gain_code_o)) else $error("gain changed w/o update");
  chk_gain_update: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tgl_edge_ff |=> gain_update_o && gain_code_o == $past(code_sync))
    else $error("gain not updated");
  chk_shift_block: assert property (@(posedge serial_clk_i) disable iff (sys_rst_i)
    load_enable_n_i |=> master_ff == $past(master_ff)) else $error("shift while enable high");
  chk_shift_msb: assert property (@(posedge serial_clk_i) disable iff (sys_rst_i)
    !load_enable_n_i |=> master_ff[0] == $past(serial_gain_in_i)) else $error("bit not captured");
  chk_slave_copy: assert property (@(negedge serial_clk_i) disable iff (sys_rst_i)
    !load_enable_n_i |=> slave_ff == $past(master_ff)) else $error("slave not copied");
  chk_latch_load: assert property (@(posedge load_enable_n_i) disable iff (sys_rst_i)
    1'b1 |=> upd_tgl_ff != $past(upd_tgl_ff)) else $error("latch event lost");
  cov_update: cover property (@(posedge clk_i) disable iff (sys_rst_i) gain_update_o);
  cov_full_gain: cover property (@(posedge clk_i) disable iff (sys_rst_i) gain_code_o == 8'hFF);
  cov_sleep: cover property (@(posedge clk_i) disable iff (sys_rst_i) $fell(fwd_amp_en_o));
endmodule // sgl_loader

// >>> tb/sgl_host_model.sv
`timescale 1ns/1ps
// host that clocks gain bits into the loader
module sgl_host_model (
  output logic serial_clk_o,
  output logic serial_gain_in_o,
  output logic load_enable_n_o
);
  localparam time HALF = 80ns; // half of the 160 ns link period
  // link clock stands still between frames
  initial begin
    serial_clk_o = 1'b0;
    serial_gain_in_o = 1'b0;
    load_enable_n_o = 1'b1;
  end
  // n serial clocks with enable at en_n; the offset keeps phase unrelated to clk_i
  task automatic send(input logic [7:0] w, input int n, input logic en_n);
    load_enable_n_o = en_n;
    #(HALF + 3.3ns);
    for (int i = n - 1; i >= 0; i--) begin
      serial_gain_in_o = w[i];
      #HALF serial_clk_o = 1'b1;
      #HALF serial_clk_o = 1'b0;
      serial_gain_in_o = ~w[i]; // released line shows the inverse
    end
  endtask
  // enable high applies the word
  task automatic apply();
    #HALF load_enable_n_o = 1'b1;
  endtask
endmodule // sgl_host_model

// >>> tb/tb.sv
`timescale 1ns/1ps
// self-checking bench for the serial gain loader
module tb;
  logic clk_i, sys_rst_i, amp_sleep_n_i; // core clock, reset, sleep
  logic sclk, serial_gain_in, en_n; // host link lines
  logic [7:0] gain_code_o; // applied code
  logic gain_update_o, fwd_amp_en_o, rev_amp_en_o; // loader outputs
  int mismatches = 0; // failed compares
  int tests_run = 0; // compares made
  // 125 MHz core clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  sgl_host_model sgl_host_model_inst (.serial_clk_o(sclk), .serial_gain_in_o(serial_gain_in), .load_enable_n_o(en_n));
  sgl_loader sgl_loader_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .serial_clk_i(sclk),
    .serial_gain_in_i(serial_gain_in), .load_enable_n_i(en_n), .amp_sleep_n_i(amp_sleep_n_i),
    .gain_code_o(gain_code_o), .gain_update_o(gain_update_o),
    .fwd_amp_en_o(fwd_amp_en_o), .rev_amp_en_o(rev_amp_en_o));
  // compare seen against expected
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic final_report();
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // shift n bits, check latch frozen, apply, check new code
  task automatic load_word(input logic [7:0] w, input int n, input logic [7:0] exp);
    logic [7:0] old;
    int k;
    old = gain_code_o;
    k = 0;
    sgl_host_model_inst.send(w, n, 1'b0);
    check(gain_code_o, old);
    sgl_host_model_inst.apply();
    while (gain_update_o !== 1'b1) begin
      @(negedge clk_i);
      k++;
      if (k > 40) begin
        mismatches++;
        $display("Error at %0t: no update pulse", $time);
        final_report();
      end
    end
    check(gain_code_o, exp);
    @(negedge clk_i);
    check({7'h00, gain_update_o}, 8'h00);
  endtask
  // msb first word, then clocks with enable high are ignored, then a short word keeps old bits
  task automatic sc_shift();
    load_word(8'hA5, 8, 8'hA5);
    sgl_host_model_inst.send(8'hFF, 8, 1'b1);
    check(gain_code_o, 8'hA5);
    load_word(8'h03, 4, 8'h53);
    load_word(8'hFF, 8, 8'hFF);
    load_word(8'h00, 8, 8'h00);
  endtask
  // sleep low then high selects the amplifier
  task automatic sc_sleep();
    for (int s = 0; s < 2; s++) begin
      amp_sleep_n_i = s[0];
      repeat (6) @(negedge clk_i);
      check({6'h00, fwd_amp_en_o, rev_amp_en_o}, s[0] ? 8'h02 : 8'h01);
    end
  endtask
  // reset, scenarios, verdict
  initial begin
    sys_rst_i = 1'b1;
    amp_sleep_n_i = 1'b1;
    repeat (5) @(negedge clk_i);
    check(gain_code_o, 8'h00);
    check({6'h00, fwd_amp_en_o, rev_amp_en_o}, 8'h01);
    sys_rst_i = 1'b0;
    sc_shift();
    sc_sleep();
    final_report();
  end
endmodule // tb
